// file: verilog/hfac_pkg.sv
// Shared constants for the host FIFO allocation device and its host controller
package hfac_pkg;
  localparam int AW = 8;
  localparam int DW = 32;
  // Device register offsets
  localparam logic [7:0] RXD_PORT   = 8'h00;
  localparam logic [7:0] TXD_PORT   = 8'h20;
  localparam logic [7:0] RXS_PORT   = 8'h40;
  localparam logic [7:0] ERR_FLAGS  = 8'h68;
  localparam logic [7:0] DROP_COUNT = 8'h6C;
  localparam logic [7:0] HW_CONFIG  = 8'h74;
  localparam logic [7:0] RX_DISCARD = 8'h78;
  localparam logic [7:0] RX_LEVELS  = 8'h7C;
  // Field positions and reset values
  localparam int SOFT_RESET_REQUEST_BIT    = 0;
  localparam int SOFT_RESET_TIMEOUT_BIT = 1;
  localparam int WIDTH_BIT   = 2;
  localparam int TXSZ_LSB    = 16;
  localparam int MBO_BIT     = 20;
  localparam int SKIP_BIT    = 31;
  localparam int RXS_LSB     = 16;
  localparam int TXERR_BIT   = 0;
  localparam int RXERR_BIT   = 1;
  localparam logic [3:0] TXSZ_RESET = 4'h5;
  localparam logic [3:0] TXSZ_MIN   = 4'h2;
  localparam logic [3:0] TXSZ_MAX   = 4'hE;
  // Buffer geometry in 32-bit words
  localparam logic [12:0] BUF_WORDS   = 13'h1000;
  localparam logic [12:0] KB_WORDS    = 13'h0100;
  localparam logic [12:0] TXS_WORDS   = 13'h0080;
  localparam logic [12:0] RX_MARGIN   = 13'h0004;
  localparam int          RXS_SHIFT   = 4;
  localparam int          TXMIL_WORDS = 512;
  localparam int          RXMIL_WORDS = 32;
  // Soft reset wait for the PHY clocks
  localparam int SOFT_RESET_REQUEST_TIMEOUT_NS  = 1000;
  localparam int CLK_NS           = 10;
  localparam int SOFT_RESET_REQUEST_TIMEOUT_CYC = (SOFT_RESET_REQUEST_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  // Host controller registers
  localparam logic [7:0] H_ADDR   = 8'h00;
  localparam logic [7:0] H_WDATA  = 8'h04;
  localparam logic [7:0] H_CMD    = 8'h08;
  localparam logic [7:0] H_STATUS = 8'h0C;
  localparam logic [7:0] H_RDATA  = 8'h10;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_REF_BIT   = 1;
  localparam int ST_TO_BIT    = 2;
  localparam int ST_READY_BIT = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : hfac_pkg

// file: verilog/hfac_if.sv
// Register link between the host controller and the device
`timescale 1ns/1ps
interface hfac_if (
  input wire logic mclk,
  input wire logic rst_b
);
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  modport dev (input mclk, input rst_b, input req, input we, input addr, input wdata,
               output rdata, output ack);
  modport hst (input mclk, input rst_b, output req, output we, output addr, output wdata,
               input rdata, input ack);
endinterface : hfac_if

// file: verilog/hfac_device.sv
// Device end: shared 16 KB buffer split into TX/RX FIFOs, MAC-side buffers, soft reset
`timescale 1ns/1ps
//
// Contract
// R1: Bus width strap readable as configuration bit
// R2: Soft reset without PHY clocks times out
// R3: Host fixes PHY then retries soft reset
// R4: Soft reset clears registers except exempt bits
// R5: Soft reset clears errors, bit self-clears
// R6: Host requests soft reset only PHY awake
// R7: First read needed before writes act
// R8: TX size minus 128-word status gives data
// R9: RX allocation is 16 KB minus TX
// R10: RX status takes one sixteenth of RX
// R11: Host programs TX size 2 to 14
// R12: RX data full four words early
// R13: Fixed MAC-side buffers 2K TX, 128 RX
// R14: TX data moves into MAC buffer freely
// R15: RX buffer overrun loses later frames
// R16: Count each frame lost to overrun
// R17: Levels exclude MAC-side buffer contents
// R18: Skip bit jumps to next frame, self-clears
// R19: Host avoids RX data reads during skip
// R20: RX status occupancy in words
// R21: RX data occupancy in rounded-up bytes
// R22: TX size bits 19:16, kilobytes, resets five
// R23: Host stops TX and RX before configuring
// R24: Occupancy falls on reads and skips
module hfac_device
  import hfac_pkg::*;
#(
  parameter int DROP_W = 16
) (
  // Register link
  hfac_if.dev              bus,
  // Straps and PHY state
  input  wire logic        bus_width_strap,
  input  wire logic        phy_clk_running,
  // Receive stream from the MAC
  input  wire logic        rx_mac_valid,
  input  wire logic [31:0] rx_mac_data,
  input  wire logic        rx_mac_last,
  input  wire logic [13:0] rx_mac_len,
  // Transmit stream to the MAC
  output logic             tx_mac_valid,
  output logic [31:0]      tx_mac_data,
  input  wire logic        tx_mac_ready
);
  import hfac_pkg::*;

  typedef enum logic [1:0] {SR_IDLE = 2'b00, SR_WAIT = 2'b01, SR_DONE = 2'b11} hfac_sr_t;

  logic [31:0]       mem [BUF_WORDS];
  logic [31:0]       txmil [TXMIL_WORDS];
  logic [46:0]       rxmil [RXMIL_WORDS];
  logic [3:0]        txsz;
  logic              mbo;
  logic              soft_reset_request_bit;
  logic              soft_reset_timeout;
  logic              strap_q;
  logic              strap_taken;
  logic              unlocked;
  hfac_sr_t          sr_state;
  logic [15:0]       sr_cnt;
  logic              tx_err;
  logic              rx_err;
  logic [DROP_W-1:0] drop_cnt;
  logic [11:0]       txd_wr, txd_rd, rxd_wr, rxd_rd, rxs_wr, rxs_rd;
  logic [12:0]       txd_cnt, rxd_cnt, rxs_cnt;
  logic [9:0]        tm_wr, tm_rd;
  logic [5:0]        rm_wr, rm_rd, rm_start, rm_commit;
  logic              dropping;
  logic              skip;
  logic [11:0]       frame_left;
  logic [31:0]       next_rdata;
  logic [12:0]       alloc_w, txd_size, rx_total, rxs_size, rxd_size, rxd_base, rxs_base;
  logic              take, rd, wr, sclr;
  logic              txd_push, rxd_pop, rxs_pop, skip_step, txm_move, rxm_move, rxm_last;
  logic [46:0]       rm_head;
  logic [9:0]        tm_cnt;
  logic [5:0]        rm_cnt;

  function automatic logic [11:0] adv(input logic [11:0] p, input logic [12:0] size);
    adv = (13'(p) + 13'h1 == size) ? 12'h000 : p + 12'h001;
  endfunction : adv

  // Partitioning of the shared buffer
  always_comb begin
    alloc_w  = 13'(txsz) * KB_WORDS;
    txd_size = alloc_w - TXS_WORDS; // R8
    rx_total = BUF_WORDS - alloc_w; // R9
    rxs_size = rx_total >> RXS_SHIFT; // R10
    rxd_size = rx_total - rxs_size; // R10
    rxd_base = alloc_w;
    rxs_base = alloc_w + rxd_size;
  end

  // Link decode; the one-cycle ack masks the still-high request
  assign take      = bus.req && !bus.ack;
  assign rd        = take && !bus.we;
  assign wr        = take && bus.we && unlocked; // R7
  assign sclr      = (sr_state == SR_DONE);
  assign txd_push  = wr && bus.addr == TXD_PORT && txd_cnt < txd_size;
  assign rxd_pop   = rd && bus.addr == RXD_PORT && rxd_cnt != 13'h0 && !skip;
  assign rxs_pop   = rd && bus.addr == RXS_PORT && rxs_cnt != 13'h0;
  assign skip_step = skip && frame_left != 12'h0 && rxd_cnt != 13'h0; // R18
  assign tm_cnt    = tm_wr - tm_rd;
  assign txm_move  = txd_cnt != 13'h0 && tm_cnt != 10'(TXMIL_WORDS); // R14
  assign rm_cnt    = rm_wr - rm_rd;
  assign rm_head   = rxmil[rm_rd[4:0]];
  assign rxm_last  = rm_head[46];
  assign rxm_move  = rm_commit != rm_rd && rxd_cnt + RX_MARGIN < rxd_size // R12
                     && (!rxm_last || rxs_cnt < rxs_size);

  // Unlock on the first read after any reset
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      unlocked <= 1'b0;
    end else if (sclr) begin
      unlocked <= 1'b0;
    end else if (rd) begin
      unlocked <= 1'b1; // R7
    end
  end

  // Strap is caught once, after reset release
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      strap_q     <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap_q     <= bus_width_strap; // R1
      strap_taken <= 1'b1;
    end
  end

  // Configuration fields; size and must-be-one survive soft reset
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      txsz <= TXSZ_RESET; // R22
      mbo  <= 1'b0;
    end else if (wr && bus.addr == HW_CONFIG) begin
      txsz <= bus.wdata[TXSZ_LSB +: 4]; // R22
      mbo  <= bus.wdata[MBO_BIT];
    end
  end

  // Soft reset sequencer
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      sr_state <= SR_IDLE;
      sr_cnt   <= 16'h0000;
      soft_reset_request_bit <= 1'b0;
      soft_reset_timeout  <= 1'b0;
    end else begin
      case (sr_state)
        SR_IDLE: begin
          if (wr && bus.addr == HW_CONFIG && bus.wdata[SOFT_RESET_REQUEST_BIT]) begin
            sr_state <= SR_WAIT;
            sr_cnt   <= 16'h0000;
            soft_reset_request_bit <= 1'b1;
          end
        end
        SR_WAIT: begin
          if (phy_clk_running) begin
            sr_state <= SR_DONE;
          end else if (sr_cnt == 16'(SOFT_RESET_REQUEST_TIMEOUT_CYC - 1)) begin
            sr_state <= SR_IDLE; // R2
            soft_reset_request_bit <= 1'b0;
            soft_reset_timeout  <= 1'b1; // R2
          end else begin
            sr_cnt <= sr_cnt + 16'h0001;
          end
        end
        SR_DONE: begin
          sr_state <= SR_IDLE;
          soft_reset_request_bit <= 1'b0; // R5
          soft_reset_timeout  <= 1'b0;
        end
        default: sr_state <= SR_IDLE;
      endcase
    end
  end

  // Error flags: write one to clear, a new error wins
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      tx_err <= 1'b0;
      rx_err <= 1'b0;
    end else if (sclr) begin
      tx_err <= 1'b0; // R5
      rx_err <= 1'b0; // R5
    end else begin
      if (wr && bus.addr == TXD_PORT && !txd_push) begin
        tx_err <= 1'b1;
      end else if (wr && bus.addr == ERR_FLAGS && bus.wdata[TXERR_BIT]) begin
        tx_err <= 1'b0;
      end
      if (rd && ((bus.addr == RXD_PORT && !rxd_pop) || (bus.addr == RXS_PORT && !rxs_pop))) begin
        rx_err <= 1'b1;
      end else if (wr && bus.addr == ERR_FLAGS && bus.wdata[RXERR_BIT]) begin
        rx_err <= 1'b0;
      end
    end
  end

  // Shared buffer writes: host TX data, RX data and RX status
  always_ff @(posedge bus.mclk) begin
    if (txd_push) begin
      mem[txd_wr] <= bus.wdata;
    end
    if (rxm_move) begin
      mem[12'(rxd_base + 13'(rxd_wr))] <= rm_head[31:0];
    end
    if (rxm_move && rxm_last) begin
      mem[12'(rxs_base + 13'(rxs_wr))] <= {2'b00, rm_head[45:32], 16'h0000};
    end
    if (txm_move) begin
      txmil[tm_wr[8:0]] <= mem[txd_rd];
    end
    if (rx_mac_valid && !dropping && rm_cnt != 6'(RXMIL_WORDS)) begin
      rxmil[rm_wr[4:0]] <= {rx_mac_last, rx_mac_len, rx_mac_data};
    end
  end

  // TX data FIFO and TX MAC-side buffer
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      txd_wr       <= 12'h000;
      txd_rd       <= 12'h000;
      txd_cnt      <= 13'h0000;
      tm_wr        <= 10'h000;
      tm_rd        <= 10'h000;
      tx_mac_valid <= 1'b0;
      tx_mac_data  <= 32'h0000_0000;
    end else if (sclr) begin
      txd_wr       <= 12'h000; // R4
      txd_rd       <= 12'h000;
      txd_cnt      <= 13'h0000;
      tm_wr        <= 10'h000;
      tm_rd        <= 10'h000;
      tx_mac_valid <= 1'b0;
    end else begin
      if (txd_push) begin
        txd_wr <= adv(txd_wr, txd_size);
      end
      if (txm_move) begin
        txd_rd <= adv(txd_rd, txd_size); // R14
        tm_wr  <= tm_wr + 10'h001;
      end
      txd_cnt <= txd_cnt + 13'(txd_push) - 13'(txm_move);
      if ((!tx_mac_valid || tx_mac_ready) && tm_cnt != 10'h000) begin
        tx_mac_valid <= 1'b1;
        tx_mac_data  <= txmil[tm_rd[8:0]];
        tm_rd        <= tm_rd + 10'h001;
      end else if (tx_mac_ready) begin
        tx_mac_valid <= 1'b0;
      end
    end
  end

  // RX MAC-side buffer: a frame that overruns is rewound and counted
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      rm_wr     <= 6'h00;
      rm_rd     <= 6'h00;
      rm_start  <= 6'h00;
      rm_commit <= 6'h00;
      dropping  <= 1'b0;
      drop_cnt  <= '0;
    end else if (sclr) begin
      rm_wr     <= 6'h00; // R4
      rm_rd     <= 6'h00;
      rm_start  <= 6'h00;
      rm_commit <= 6'h00;
      dropping  <= 1'b0;
      drop_cnt  <= '0;
    end else begin
      if (rx_mac_valid) begin
        if (dropping) begin
          dropping <= !rx_mac_last; // R15
        end else if (rm_cnt == 6'(RXMIL_WORDS)) begin
          rm_wr    <= rm_start; // R15
          dropping <= !rx_mac_last;
          drop_cnt <= drop_cnt + 1'b1; // R16
        end else begin
          rm_wr <= rm_wr + 6'h01;
          if (rx_mac_last) begin
            rm_start  <= rm_wr + 6'h01;
            rm_commit <= rm_wr + 6'h01;
          end
        end
      end
      if (rxm_move) begin
        rm_rd <= rm_rd + 6'h01; // R15
      end
    end
  end

  // RX data and status FIFOs, skip to next frame
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      rxd_wr     <= 12'h000;
      rxd_rd     <= 12'h000;
      rxd_cnt    <= 13'h0000;
      rxs_wr     <= 12'h000;
      rxs_rd     <= 12'h000;
      rxs_cnt    <= 13'h0000;
      skip       <= 1'b0;
      frame_left <= 12'h000;
    end else if (sclr) begin
      rxd_wr     <= 12'h000; // R4
      rxd_rd     <= 12'h000;
      rxd_cnt    <= 13'h0000;
      rxs_wr     <= 12'h000;
      rxs_rd     <= 12'h000;
      rxs_cnt    <= 13'h0000;
      skip       <= 1'b0;
      frame_left <= 12'h000;
    end else begin
      if (rxm_move) begin
        rxd_wr <= adv(rxd_wr, rxd_size);
      end
      if (rxm_move && rxm_last) begin
        rxs_wr <= adv(rxs_wr, rxs_size);
      end
      if (rxd_pop || skip_step) begin
        rxd_rd <= adv(rxd_rd, rxd_size); // R24
      end
      rxd_cnt <= rxd_cnt + 13'(rxm_move) - 13'(rxd_pop || skip_step); // R24
      if (rxs_pop) begin
        rxs_rd     <= adv(rxs_rd, rxs_size);
        frame_left <= 12'((mem[12'(rxs_base + 13'(rxs_rd))][29:16] + 14'h0003) >> 2);
      end else if ((rxd_pop || skip_step) && frame_left != 12'h000) begin
        frame_left <= frame_left - 12'h001;
      end
      rxs_cnt <= rxs_cnt + 13'(rxm_move && rxm_last) - 13'(rxs_pop); // R24
      if (wr && bus.addr == RX_DISCARD && bus.wdata[SKIP_BIT]) begin
        skip <= 1'b1; // R18
      end else if (skip && frame_left == 12'h000) begin
        skip <= 1'b0; // R18
      end
    end
  end

  // Read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (bus.addr)
      RXD_PORT:   next_rdata = rxd_pop ? mem[12'(rxd_base + 13'(rxd_rd))] : 32'h0000_0000;
      RXS_PORT:   next_rdata = rxs_pop ? mem[12'(rxs_base + 13'(rxs_rd))] : 32'h0000_0000;
      ERR_FLAGS:  next_rdata = {30'h0, rx_err, tx_err};
      DROP_COUNT: next_rdata = 32'(drop_cnt); // R16
      HW_CONFIG:  next_rdata = {11'h0, mbo, txsz, 13'h0, strap_q, soft_reset_timeout, soft_reset_request_bit}; // R1
      RX_DISCARD: next_rdata = {skip, 31'h0}; // R18
      RX_LEVELS:  next_rdata = {8'h0, rxs_cnt[7:0], 1'b0, rxd_cnt, 2'b00}; // R17
      default:    next_rdata = 32'h0000_0000;
    endcase
  end

  // Answer one cycle after the request is taken
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      bus.ack   <= 1'b0;
      bus.rdata <= 32'h0000_0000;
    end else begin
      bus.ack <= take;
      if (rd) begin
        bus.rdata <= next_rdata; // R20 R21
      end
    end
  end
endmodule : hfac_device

// file: verilog/hfac_host.sv
// Host end: AXI4-Lite command registers driving device register accesses
`timescale 1ns/1ps
module hfac_host
  import hfac_pkg::*;
(
  // Device link
  hfac_if.hst              bus,
  // System state seen by the host
  input  wire logic        phy_awake,
  input  wire logic        mac_stopped,
  // AXI4-Lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);
  import hfac_pkg::*;

  typedef enum logic [1:0] {ST_BOOT = 2'b00, ST_IDLE = 2'b01, ST_WAIT = 2'b11, ST_POLL = 2'b10} hfac_hst_t;

  hfac_hst_t   state;
  logic [7:0]  tgt_addr, aw_q;
  logic [31:0] tgt_wdata, rd_q, w_q, poll_mask;
  logic        aw_ok, w_ok, refused, sr_timeout, ready;
  logic        cmd_wr, bad, launch, st_clr;

  assign cmd_wr = aw_ok && w_ok && !s_axi_bvalid;
  // Orders that would break the device's usage terms are refused
  assign bad    = w_q[0] && tgt_addr == HW_CONFIG &&
                  (!mac_stopped // R23
                   || tgt_wdata[TXSZ_LSB +: 4] < TXSZ_MIN || tgt_wdata[TXSZ_LSB +: 4] > TXSZ_MAX // R11
                   || (tgt_wdata[SOFT_RESET_REQUEST_BIT] && !phy_awake)); // R6
  assign launch = cmd_wr && aw_q == H_CMD && state == ST_IDLE && !bad;
  assign st_clr = cmd_wr && aw_q == H_STATUS && w_q[ST_REF_BIT];

  // AXI write channels, taken in either order
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_ok         <= 1'b0;
      w_ok          <= 1'b0;
      aw_q          <= 8'h00;
      w_q           <= 32'h0000_0000;
      tgt_addr      <= 8'h00;
      tgt_wdata     <= 32'h0000_0000;
    end else begin
      s_axi_awready <= !aw_ok && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_ok && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok <= 1'b1;
        aw_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok <= 1'b1;
        w_q  <= s_axi_wdata;
      end
      if (cmd_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_q == H_ADDR || aw_q == H_WDATA || aw_q == H_CMD || aw_q == H_STATUS)
                        ? RESP_OKAY : RESP_SLVERR;
        if (aw_q == H_ADDR && s_axi_wstrb[0]) begin
          tgt_addr <= w_q[7:0];
        end
        if (aw_q == H_WDATA) begin
          tgt_wdata <= w_q;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_ok        <= 1'b0;
        w_ok         <= 1'b0;
      end
    end
  end

  // AXI read channel
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr)
        H_ADDR:   s_axi_rdata <= {24'h0, tgt_addr};
        H_WDATA:  s_axi_rdata <= tgt_wdata;
        H_STATUS: s_axi_rdata <= {28'h0, ready, sr_timeout, refused, state != ST_IDLE};
        H_RDATA:  s_axi_rdata <= rd_q;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Refusal flag: a new refusal wins over the clear
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      refused <= 1'b0;
    end else if (cmd_wr && aw_q == H_CMD && (state != ST_IDLE || bad)) begin
      refused <= 1'b1;
    end else if (st_clr) begin
      refused <= 1'b0;
    end
  end

  // Link sequencer: boot read, command, and polling of self-clearing bits
  always_ff @(posedge bus.mclk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      state      <= ST_BOOT;
      bus.req    <= 1'b0;
      bus.we     <= 1'b0;
      bus.addr   <= 8'h00;
      bus.wdata  <= 32'h0000_0000;
      rd_q       <= 32'h0000_0000;
      poll_mask  <= 32'h0000_0000;
      sr_timeout <= 1'b0;
      ready      <= 1'b0;
    end else begin
      case (state)
        ST_BOOT: begin
          bus.req  <= 1'b1; // R7
          bus.we   <= 1'b0;
          bus.addr <= HW_CONFIG;
          state    <= ST_WAIT;
        end
        ST_IDLE: begin
          if (launch) begin
            bus.req   <= 1'b1;
            bus.we    <= w_q[0];
            bus.addr  <= tgt_addr;
            bus.wdata <= tgt_wdata;
            state     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (bus.ack) begin
            bus.req <= 1'b0;
            ready   <= 1'b1; // R7
            state   <= ST_IDLE;
            if (!bus.we) begin
              rd_q <= bus.rdata;
            end
            if (bus.we && bus.addr == RX_DISCARD && bus.wdata[SKIP_BIT]) begin
              poll_mask <= 32'h1 << SKIP_BIT; // R19
              state     <= ST_POLL;
            end else if (bus.we && bus.addr == HW_CONFIG && bus.wdata[SOFT_RESET_REQUEST_BIT]) begin
              poll_mask  <= 32'h1 << SOFT_RESET_REQUEST_BIT;
              sr_timeout <= 1'b0;
              state      <= ST_POLL;
            end else if (!bus.we && (bus.rdata & poll_mask) != 32'h0) begin
              state <= ST_POLL; // R19
            end else if (!bus.we && poll_mask != 32'h0) begin
              poll_mask <= 32'h0000_0000;
              if (bus.addr == HW_CONFIG) begin
                sr_timeout <= bus.rdata[SOFT_RESET_TIMEOUT_BIT]; // R3
              end
            end
          end
        end
        ST_POLL: begin
          bus.req <= 1'b1;
          bus.we  <= 1'b0;
          state   <= ST_WAIT;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : hfac_host

// file: sim/hfac_properties.sv
// Link protocol checks between the host end and the device end
`timescale 1ns/1ps
module hfac_properties
  import hfac_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // Link signals
  input wire logic        req,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_rd(logic [7:0] a);
    ack && !we && addr == a;
  endsequence
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
  a_take_answer: assert property (s_take |=> ack) else $error("no ack");
  a_no_stray: assert property (!req |=> !ack) else $error("stray ack");
  a_req_release: assert property (ack |=> !req) else $error("req held");
  a_req_hold: assert property (s_take |=> $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request moved");
  a_level_rsvd: assert property (s_rd(RX_LEVELS) |-> rdata[31:24] == 8'h00) else $error("levels");
  a_skip_rsvd: assert property (s_rd(RX_DISCARD) |-> rdata[30:0] == 31'h0) else $error("skip");
  a_cfg_rsvd: assert property (s_rd(HW_CONFIG) |-> rdata[31:21] == 11'h0 && rdata[15:3] == 13'h0)
    else $error("config");
endmodule : hfac_properties

// file: sim/tb_top.sv
// Testbench joining host and device ends through the link
`timescale 1ns/1ps
module tb_top;
  import hfac_pkg::*;
  logic        mclk = 0, rst_b = 0, strap = 1, phy_clk = 1, rx_v = 0, rx_l = 0, tx_v, stop = 1, awake = 1;
  logic        awv = 0, awr, wv = 0, wr, bv, br = 0, arv = 0, arr, rv, rr = 0;
  logic [31:0] rx_d = 0, tx_d, x, wd = 0, rdat, tq;
  logic [13:0] rx_len = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [1:0]  bresp, rresp, resp;
  int          n_fail = 0, check_count = 0;
  hfac_if bus (.mclk(mclk), .rst_b(rst_b));
  hfac_device i_hfac_device (.bus(bus), .bus_width_strap(strap), .phy_clk_running(phy_clk),
    .rx_mac_valid(rx_v), .rx_mac_data(rx_d), .rx_mac_last(rx_l), .rx_mac_len(rx_len),
    .tx_mac_valid(tx_v), .tx_mac_data(tx_d), .tx_mac_ready(1'b1));
  hfac_host i_hfac_host (.bus(bus), .phy_awake(awake), .mac_stopped(stop), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp));
  hfac_properties i_hfac_properties (.mclk(mclk), .rst_b(rst_b), .req(bus.req), .we(bus.we),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack));
  initial forever #5 mclk = ~mclk;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge mclk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (!bv);
    br <= 0;
    @(posedge mclk);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    ara <= a; arv <= 1; rr <= 1;
    do begin
      @(posedge mclk);
      if (arr) arv <= 0;
    end while (!rv);
    rr <= 0; d = rdat; resp = rresp;
    @(posedge mclk);
  endtask : axr
  // Device access; the host is polled for busy
  task automatic dev(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    axw(H_ADDR, {24'h0, a});
    axw(H_WDATA, d);
    axw(H_CMD, {31'h0, w});
    do axr(H_STATUS, q); while (q[ST_BUSY_BIT] !== 1'b0);
    axr(H_RDATA, q);
  endtask : dev
  task automatic rxf(input int nw, input logic [13:0] len);
    for (int i = 0; i < nw; i++) begin
      rx_v <= 1; rx_d <= 32'(i); rx_l <= (i == nw - 1); rx_len <= len;
      @(posedge mclk);
    end
    rx_v <= 0; rx_l <= 0;
    repeat (40) @(posedge mclk);
  endtask : rxf
  task automatic t_boot;
    dev(0, HW_CONFIG, 0, x); chk("config", 32'h0005_0004, x);
    dev(0, RX_LEVELS, 0, x); chk("levels", 0, x);
    dev(0, RXD_PORT, 0, x);
    dev(0, ERR_FLAGS, 0, x); chk("errors", 32'h2, x);
    dev(0, 8'hF0, 0, x); chk("unmapped", 0, x);
    axr(8'hF0, x); chk("resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
  endtask : t_boot
  task automatic t_cfg;
    for (int v = 2; v <= 15; v++) begin
      stop <= v != 9;
      dev(1, HW_CONFIG, 32'h0010_0000 | (v << 16), x);
      dev(0, HW_CONFIG, 0, x); chk("size", v == 9 || v == 15 ? v - 1 : v, 32'(x[19:16]));
    end
    axr(H_STATUS, x); chk("refused", 1, 32'(x[ST_REF_BIT]));
  endtask : t_cfg
  task automatic t_rx;
    rxf(3, 14'd10);
    dev(0, RX_LEVELS, 0, x); chk("lev", 32'h0001_000C, x);
    dev(0, RXS_PORT, 0, x); chk("len", 10, 32'(x[29:16]));
    dev(0, RXD_PORT, 0, x); chk("word", 0, x);
    dev(0, RX_LEVELS, 0, x); chk("lev", 32'h8, x);
    dev(1, RX_DISCARD, 32'h8000_0000, x);
    dev(0, RX_LEVELS, 0, x); chk("skip", 0, x);
  endtask : t_rx
  task automatic t_tx;
    fork
      dev(1, TXD_PORT, 32'hA5C3_0F96, x);
      begin do @(posedge mclk); while (!tx_v); tq = tx_d; end
    join
    chk("tx", 32'hA5C3_0F96, tq);
  endtask : t_tx
  // 480-word data FIFO at size 14 takes 29 frames of 16; MAC buffer two more
  task automatic t_drop;
    repeat (40) rxf(16, 14'd64);
    dev(0, DROP_COUNT, 0, x); chk("drop", 9, x);
    dev(0, RX_LEVELS, 0, x); chk("full", 32'h001D_0770, x);
  endtask : t_drop
  task automatic t_soft_reset_request;
    phy_clk <= 0;
    awake <= 0;
    dev(1, HW_CONFIG, 32'h001E_0001, x);
    awake <= 1;
    dev(0, HW_CONFIG, 0, x); chk("early", 0, 32'(x[1:0]));
    dev(1, HW_CONFIG, 32'h001E_0001, x);
    dev(0, HW_CONFIG, 0, x); chk("timeout", 2, 32'(x[1:0]));
    phy_clk <= 1;
    dev(1, HW_CONFIG, 32'h001E_0001, x);
    dev(0, HW_CONFIG, 0, x); chk("kept", 32'h001E_0004, x);
    dev(0, DROP_COUNT, 0, x); chk("drop0", 0, x);
    dev(0, RX_LEVELS, 0, x); chk("lev0", 0, x);
    dev(0, ERR_FLAGS, 0, x); chk("err0", 0, x);
  endtask : t_soft_reset_request
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1;
    repeat (2) @(posedge mclk);
    t_boot;
    t_cfg;
    t_rx;
    t_tx;
    t_drop;
    t_soft_reset_request;
    stop_test;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    stop_test;
  end
endmodule : tb_top
